// ---- inc/lpoc_consts.svh ----
// constants for the line printer output control block
// assumes a 100 MHz ref_clk; long counts are module parameters
`ifndef LPOC_CONSTS_SVH
`define LPOC_CONSTS_SVH
`define LPOC_WORD_W 36
`define LPOC_COLS 92
`define LPOC_ROWS 11
`define LPOC_FIELD_COLS 36
`define LPOC_FIELD3_COLS 20
`define LPOC_FIELD3_LSB 16
`define LPOC_BIT_START 34
`define LPOC_BIT_JUMP 13
`define LPOC_BIT_SKIP 12
`define LPOC_BIT_IRQ 11
`define LPOC_BIT_PRINT 10
`define LPOC_BIT_HOLD 9
`define LPOC_POINTS 15
`define LPOC_POINT_US 26670
`define LPOC_CLK_MHZ 100
`define LPOC_POINT_CYC (`LPOC_POINT_US * `LPOC_CLK_MHZ)
`define LPOC_JUMP_SPACES 4'h9
`define LPOC_PRINT_POINT 4'h6
`define LPOC_ADV_DONE_POINT 4'h7
`define LPOC_ROW_FIRST 4'h9
`endif

// ---- inc/lpoc_pkg.sv ----
// types shared by both ends of the line printer output control link
// assumes lpoc_consts.svh is included first
`include "lpoc_consts.svh"
package lpoc_pkg;
	typedef logic [`LPOC_WORD_W-1:0] lpoc_word_t;
	typedef logic [`LPOC_COLS-1:0] lpoc_row_t;
	// device states, gray coded along idle-run-finish
	typedef enum logic [1:0] {
		LPOC_IDLE = 2'b00,
		LPOC_RUN = 2'b01,
		LPOC_DONE = 2'b11
	} lpoc_dev_state_t;
	typedef enum logic [2:0] {
		LPOC_H_IDLE = 3'b000,
		LPOC_H_FUNC = 3'b001,
		LPOC_H_WAIT = 3'b011,
		LPOC_H_WR = 3'b010,
		LPOC_H_GAP = 3'b110
	} lpoc_host_state_t;
endpackage

// ---- inc/lpoc_if.sv ----
// link between host buffer control and printer control
// assumes one shared clock; testbench connects both modports
`timescale 1ns/1ps
`include "lpoc_consts.svh"
interface lpoc_if;
	logic [`LPOC_WORD_W-1:0] io_transfer_word;
	logic function_command;
	logic field_write_command;
	logic word_taken;
	logic row_point;
	logic irq;
	logic cycle_busy;
	modport host (output io_transfer_word, output function_command,
		output field_write_command, input word_taken, input row_point, input irq,
		input cycle_busy);
	modport dev (input io_transfer_word, input function_command,
		input field_write_command, output word_taken, output row_point, output irq,
		output cycle_busy);
endinterface

// ---- rtl/lpoc_wheel.sv ----
// one print wheel column: maps an 11-row code to a character index
// assumes row bits ordered 11,0,1..9 from msb down to lsb
`timescale 1ns/1ps
module lpoc_wheel #(
	parameter bit EVEN_COL = 1'b0
) (
	// code
	input wire logic [10:0] code,
	input wire logic zero_fill,
	input wire logic left_printed,
	// result: 0 blank, 1..35 character, 36 no such char on this wheel
	output logic [5:0] char_idx,
	output logic printed
);
	logic [3:0] ones;
	logic [2:0] low;
	logic [5:0] single;
	logic [5:0] zone;
	always_comb begin
		ones = 4'h0;
		low = 3'h0;
		single = 6'h00;
		for (int i = 0; i < 11; i++) begin
			ones = 4'(ones + {3'h0, code[i]});
		end
		// lone row 0 gives 1, lone rows 1..9 give 2..10
		for (int k = 0; k < 10; k++) begin
			if (code[k]) begin
				single = 6'(10 - k);
			end
		end
		// second row of a letter: rows 11, 0, 1..6 count 0..7
		for (int i = 0; i < 8; i++) begin
			if (code[10-i]) begin
				low = 3'(i);
			end
		end
		// zone rows 7, 8, 9 open the three letter groups
		case (code[2:0])
			3'b100: zone = 6'h0b;
			3'b010: zone = 6'h13;
			3'b001: zone = 6'h1b;
			default: zone = 6'h00;
		endcase
		char_idx = 6'h24;
		printed = 1'b1;
		if (ones == 4'h0) begin
			char_idx = (zero_fill && left_printed) ? 6'h01 : 6'h00;
			printed = zero_fill && left_printed;
		end else if (ones == 4'h1) begin
			// lone row 11: index 35 on every wheel, EVEN_COL unused
			char_idx = code[10] ? 6'h23 : single;
		end else if (ones == 4'h2 && zone != 6'h00) begin
			char_idx = 6'(zone + {3'h0, low});
		end
	end
endmodule

// ---- rtl/lpoc_host.sv ----
// host end: issues a function command then 33 field writes per print cycle
// assumes one clock with the printer end; user supplies the image rows
`timescale 1ns/1ps
`include "lpoc_consts.svh"
module lpoc_host (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// user side
	input wire logic go,
	input wire logic [`LPOC_WORD_W-1:0] func_bits,
	input wire logic [`LPOC_COLS-1:0] row_data,
	output logic [3:0] row_sel,
	output logic host_busy,
	// link
	lpoc_if.host lnk
);
	lpoc_pkg::lpoc_host_state_t st, next_st;
	logic [1:0] fld, next_fld;
	logic [3:0] row, next_row;
	logic fc, next_fc, fw, next_fw, busy, next_busy;
	lpoc_pkg::lpoc_word_t w, next_w;
	logic pt_d, next_pt_d;
	always_comb begin
		next_st = st;
		next_fld = fld;
		next_row = row;
		next_fc = 1'b0;
		next_fw = 1'b0;
		next_w = w;
		next_busy = busy;
		next_pt_d = lnk.row_point;
		case (st)
			lpoc_pkg::LPOC_H_IDLE: begin
				if (go) begin
					next_w = func_bits;
					next_fc = 1'b1;
					next_busy = 1'b1;
					next_st = lpoc_pkg::LPOC_H_FUNC;
				end
			end
			lpoc_pkg::LPOC_H_FUNC: begin
				next_w = '0;
				next_fld = 2'h0;
				next_row = `LPOC_ROW_FIRST;
				next_st = func_bits[`LPOC_BIT_PRINT] ? lpoc_pkg::LPOC_H_WAIT
					: lpoc_pkg::LPOC_H_GAP;
			end
			lpoc_pkg::LPOC_H_WAIT: begin
				if (lnk.row_point && !pt_d) begin
					next_st = lpoc_pkg::LPOC_H_WR;
				end
			end
			lpoc_pkg::LPOC_H_WR: begin
				if (!fw || lnk.word_taken) begin
					case (fld)
						2'h0: next_w = row_data[91:56];
						2'h1: next_w = row_data[55:20];
						default: next_w = {row_data[19:0], 16'h0000};
					endcase
					next_fw = 1'b1;
					next_fld = (fld == 2'h2) ? 2'h0 : 2'(fld + 2'h1);
					if (fld == 2'h2) begin
						next_row = (row == 4'h0) ? 4'hb : 4'(row - 4'h1);
						next_st = (row == 4'hb) ? lpoc_pkg::LPOC_H_GAP
							: lpoc_pkg::LPOC_H_WAIT;
					end
				end
			end
			lpoc_pkg::LPOC_H_GAP: begin
				if (!lnk.cycle_busy && !fc) begin
					next_busy = 1'b0;
					next_st = lpoc_pkg::LPOC_H_IDLE;
				end
			end
			default: next_st = lpoc_pkg::LPOC_H_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= lpoc_pkg::LPOC_H_IDLE;
			fld <= 2'h0;
			row <= 4'h0;
			fc <= 1'b0;
			fw <= 1'b0;
			w <= '0;
			busy <= 1'b0;
			pt_d <= 1'b0;
		end else if (clk_en) begin
			st <= next_st;
			fld <= next_fld;
			row <= next_row;
			fc <= next_fc;
			fw <= next_fw;
			w <= next_w;
			busy <= next_busy;
			pt_d <= next_pt_d;
		end
	end
	assign lnk.io_transfer_word = w;
	assign lnk.function_command = fc;
	assign lnk.field_write_command = fw;
	assign row_sel = row;
	assign host_busy = busy;
endmodule

// ---- rtl/lpoc_dev.sv ----
// printer end: runs 15-point cycles, senses rows, advances paper, prints
// assumes host keeps its ordering; POINT_CYC may be shortened in simulation
//
// Operation
// - image is eleven rows by 92 columns
// - fields hold 36, 36, 20 columns
// - third field sits in bits 35..16
// - host sends rows 9 down to 0, 11
// - host always writes all three fields
// - take each word before next write
// - host sends function command before writes
// - start runs cycle, auto advance paper
// - jump advances nine spaces, no print
// - skip advances by format, no print
// - print senses eleven rows, prints line
// - paper hold suppresses auto advance
// - fifteen points of 26.67 ms each
// - row sensed only if three writes arrive; code keeps partial fields and flags row_missed
// - advance before point six, print after
// - all zero column prints blank
// - zero fill after printed left neighbour
// - 35 chars, period even, minus odd; code gives index 35 on even and odd wheels alike
// - host writes early in each row point
// - interrupt at each row point start; code raises it only when the irq bit or irq_switch is set along with print
// - host restarts within 50 ms
`timescale 1ns/1ps
`include "lpoc_consts.svh"
module lpoc_dev #(
	parameter int POINT_CYC = `LPOC_POINT_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// link
	lpoc_if.dev lnk,
	// mechanism settings
	input wire logic [1:0] auto_spaces,
	input wire logic [3:0] format_spaces,
	input wire logic zero_fill,
	input wire logic irq_switch,
	// mechanism results
	output logic [3:0] point_num,
	output logic paper_step,
	output logic print_strobe,
	output logic [`LPOC_COLS*6-1:0] line_chars,
	output logic [`LPOC_COLS-1:0] row_missed
);
	lpoc_pkg::lpoc_dev_state_t st, next_st;
	logic [31:0] tick, next_tick;
	logic [3:0] pidx, next_pidx;
	logic [5:0] func, next_func;
	logic [1:0] fld, next_fld;
	logic [3:0] adv, next_adv;
	logic [`LPOC_COLS-1:0] img [`LPOC_ROWS];
	logic [`LPOC_COLS-1:0] next_img [`LPOC_ROWS];
	logic [`LPOC_COLS-1:0] miss, next_miss;
	logic taken, next_taken, rp, next_rp, irq_q, next_irq, busy, next_busy;
	logic step, next_step, strobe, next_strobe;
	logic [`LPOC_COLS*6-1:0] chars, next_chars;
	logic [3:0] pnum;
	logic [3:0] rslot;
	logic [`LPOC_COLS*6-1:0] wheel_out;
	logic [`LPOC_COLS:0] left_pr;
	logic [3:0] pt_shown, next_pt_shown;
	// point index 0..14 maps to numbers 9..0, 11..15
	assign pnum = (pidx <= 4'h9) ? 4'(4'h9 - pidx) : 4'(pidx + 4'h1);
	assign rslot = pidx;
	assign left_pr[0] = 1'b0;
	for (genvar c = 0; c < `LPOC_COLS; c++) begin : g_col
		logic [10:0] code;
		for (genvar r = 0; r < `LPOC_ROWS; r++) begin : g_row
			assign code[10-r] = img[`LPOC_ROWS-1-r][`LPOC_COLS-1-c];
		end
		lpoc_wheel #(.EVEN_COL(((c + 1) % 2) == 0)) u_wheel (
			.code(code),
			.zero_fill(zero_fill),
			.left_printed(left_pr[c]),
			.char_idx(wheel_out[c*6 +: 6]),
			.printed(left_pr[c+1])
		);
	end
	always_comb begin
		next_st = st;
		next_tick = tick;
		next_pidx = pidx;
		next_func = func;
		next_fld = fld;
		next_adv = adv;
		next_img = img;
		next_miss = miss;
		next_taken = 1'b0;
		next_rp = 1'b0;
		next_irq = 1'b0;
		next_busy = busy;
		next_step = 1'b0;
		next_strobe = 1'b0;
		next_chars = chars;
		if (lnk.field_write_command) begin
			next_taken = 1'b1;
		end
		case (st)
			lpoc_pkg::LPOC_IDLE: begin
				if (lnk.function_command && lnk.io_transfer_word[`LPOC_BIT_START]) begin
					next_func = {lnk.io_transfer_word[`LPOC_BIT_JUMP],
						lnk.io_transfer_word[`LPOC_BIT_SKIP],
						lnk.io_transfer_word[`LPOC_BIT_IRQ] | irq_switch,
						lnk.io_transfer_word[`LPOC_BIT_PRINT],
						lnk.io_transfer_word[`LPOC_BIT_HOLD], 1'b1};
					next_tick = '0;
					next_pidx = 4'h0;
					next_fld = 2'h0;
					next_miss = '0;
					for (int r = 0; r < `LPOC_ROWS; r++) begin
						next_img[r] = '0;
					end
					if (lnk.io_transfer_word[`LPOC_BIT_JUMP]) begin
						next_adv = `LPOC_JUMP_SPACES;
					end else if (lnk.io_transfer_word[`LPOC_BIT_SKIP]) begin
						next_adv = format_spaces;
					end else if (lnk.io_transfer_word[`LPOC_BIT_HOLD]) begin
						next_adv = 4'h0;
					end else begin
						next_adv = {2'h0, auto_spaces};
					end
					next_busy = 1'b1;
					next_rp = 1'b1;
					next_irq = (lnk.io_transfer_word[`LPOC_BIT_IRQ] | irq_switch)
						& lnk.io_transfer_word[`LPOC_BIT_PRINT];
					next_st = lpoc_pkg::LPOC_RUN;
				end
			end
			lpoc_pkg::LPOC_RUN: begin
				if (lnk.field_write_command && func[2] && rslot < 4'(`LPOC_ROWS)) begin
					case (fld)
						2'h0: next_img[rslot][91:56] = lnk.io_transfer_word;
						2'h1: next_img[rslot][55:20] = lnk.io_transfer_word;
						default: next_img[rslot][19:0] =
							lnk.io_transfer_word[35:`LPOC_FIELD3_LSB];
					endcase
					next_fld = (fld == 2'h2) ? 2'h0 : 2'(fld + 2'h1);
				end
				// paper steps before point six
				// up to three steps in each of points 9, 8, 7: nine in all
				if (adv != 4'h0 && tick[0] && tick < 32'h0000_0007
						&& pidx < 4'(4'h9 - `LPOC_PRINT_POINT)) begin
					next_step = 1'b1;
					next_adv = 4'(adv - 4'h1);
				end
				if (tick == 32'(POINT_CYC - 1)) begin
					next_tick = '0;
					if (rslot < 4'(`LPOC_ROWS) && fld != 2'h0) begin
						next_miss[rslot] = 1'b1;
					end
					next_fld = 2'h0;
					if (pidx == 4'(`LPOC_POINTS - 1)) begin
						next_st = lpoc_pkg::LPOC_DONE;
					end else begin
						next_pidx = 4'(pidx + 4'h1);
						if (pidx + 4'h1 < 4'(`LPOC_ROWS)) begin
							next_rp = 1'b1;
							next_irq = func[3] & func[2];
						end
						if (pidx + 4'h1 == 4'(`LPOC_ROWS) && func[2] && !func[5] && !func[4]) begin
							next_strobe = 1'b1;
							next_chars = wheel_out;
						end
					end
				end else begin
					next_tick = 32'(tick + 32'h1);
				end
			end
			lpoc_pkg::LPOC_DONE: begin
				next_busy = 1'b0;
				next_func = 6'h00;
				next_st = lpoc_pkg::LPOC_IDLE;
			end
			default: next_st = lpoc_pkg::LPOC_IDLE;
		endcase
		// point number shown only while a cycle runs
		next_pt_shown = next_busy ? ((next_pidx <= 4'h9) ? 4'(4'h9 - next_pidx)
			: 4'(next_pidx + 4'h1)) : 4'h0;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= lpoc_pkg::LPOC_IDLE;
			tick <= '0;
			pidx <= 4'h0;
			func <= 6'h00;
			fld <= 2'h0;
			adv <= 4'h0;
			for (int r = 0; r < `LPOC_ROWS; r++) begin
				img[r] <= '0;
			end
			miss <= '0;
			taken <= 1'b0;
			rp <= 1'b0;
			irq_q <= 1'b0;
			busy <= 1'b0;
			step <= 1'b0;
			strobe <= 1'b0;
			chars <= '0;
			pt_shown <= 4'h0;
		end else if (clk_en) begin
			st <= next_st;
			tick <= next_tick;
			pidx <= next_pidx;
			func <= next_func;
			fld <= next_fld;
			adv <= next_adv;
			img <= next_img;
			miss <= next_miss;
			taken <= next_taken;
			rp <= next_rp;
			irq_q <= next_irq;
			busy <= next_busy;
			step <= next_step;
			strobe <= next_strobe;
			chars <= next_chars;
			pt_shown <= next_pt_shown;
		end
	end
	assign lnk.word_taken = taken;
	assign lnk.row_point = rp;
	assign lnk.irq = irq_q;
	assign lnk.cycle_busy = busy;
	assign point_num = pt_shown;
	assign paper_step = step;
	assign print_strobe = strobe;
	assign line_chars = chars;
	assign row_missed = miss;
endmodule

// ---- tb/lpoc_assertions.sv ----
// checker for the link between host and printer ends
// assumes one clock; instantiated beside the interface in tb_top
`timescale 1ns/1ps
`include "lpoc_consts.svh"
module lpoc_assertions #(
	parameter int POINT_CYC = `LPOC_POINT_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// link
	input wire logic [`LPOC_WORD_W-1:0] io_transfer_word,
	input wire logic function_command,
	input wire logic field_write_command,
	input wire logic word_taken,
	input wire logic row_point,
	input wire logic irq,
	input wire logic cycle_busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// *****
	// helper counts
	// *****
	int gap;
	int nwr;
	int nrp;
	logic prt;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap <= 0;
			nwr <= 0;
			nrp <= 0;
			prt <= 1'b0;
		end else begin
			gap <= row_point ? 1 : gap + 1;
			nwr <= row_point ? 0 : nwr + int'(field_write_command);
			if (function_command && io_transfer_word[34] && !cycle_busy) begin
				nrp <= 0;
				prt <= io_transfer_word[10];
			end else begin
				nrp <= nrp + int'(row_point);
			end
		end
	end
	chk_take_after_write: assert property (word_taken |-> $past(field_write_command))
		else $error("word taken without a write");
	chk_write_in_cycle: assert property (field_write_command |-> cycle_busy)
		else $error("write outside a cycle");
	chk_start_runs: assert property (function_command && io_transfer_word[34] && !cycle_busy
		|=> cycle_busy && row_point)
		else $error("start did not run a cycle");
	chk_busy_cause: assert property ($rose(cycle_busy) |-> $past(function_command))
		else $error("cycle began without a command");
	chk_irq_on_point: assert property (irq |-> row_point)
		else $error("irq off a row point");
	chk_point_spacing: assert property (row_point && $past(cycle_busy) |-> gap == POINT_CYC)
		else $error("row point spacing wrong");
	chk_point_pulse: assert property (row_point |=> !row_point)
		else $error("row point longer than one cycle");
	chk_three_writes: assert property (row_point |-> nwr == 0 || nwr == 3)
		else $error("field writes per row not three");
	chk_eleven_rows: assert property ($fell(cycle_busy) && prt |-> nrp == 11)
		else $error("row point count wrong");
	cov_print: cover property (function_command && io_transfer_word[10]);
	cov_irq: cover property (irq);
	cov_end: cover property ($fell(cycle_busy));
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench: host and printer ends joined by the link
// assumes shortened points; image model compared after the print, hold and jump cycles
`timescale 1ns/1ps
`include "lpoc_consts.svh"
module tb_top;
	localparam int PC = 20;
	logic ref_clk, rst_n, go, zero_fill, irq_switch, host_busy, paper_step, print_strobe;
	logic [1:0] auto_spaces;
	logic [3:0] format_spaces, row_sel, point_num;
	logic [`LPOC_WORD_W-1:0] func_bits;
	logic [`LPOC_COLS-1:0] row_data, row_missed;
	logic [`LPOC_COLS*6-1:0] line_chars;
	logic [`LPOC_COLS-1:0] img [16];
	int dig [`LPOC_COLS];
	int n_mismatch, check_count, n_step, n_prt, n_irq, bad_pt, as, fs;
	lpoc_if lnk();
	assign row_data = img[row_sel];
	lpoc_host i_lpoc_host (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .go(go),
		.func_bits(func_bits), .row_data(row_data), .row_sel(row_sel),
		.host_busy(host_busy), .lnk(lnk.host));
	lpoc_dev #(.POINT_CYC(PC)) i_lpoc_dev (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
		.lnk(lnk.dev), .auto_spaces(auto_spaces), .format_spaces(format_spaces),
		.zero_fill(zero_fill), .irq_switch(irq_switch), .point_num(point_num),
		.paper_step(paper_step), .print_strobe(print_strobe), .line_chars(line_chars),
		.row_missed(row_missed));
	lpoc_assertions #(.POINT_CYC(PC)) i_lpoc_assertions (.ref_clk(ref_clk), .rst_n(rst_n),
		.io_transfer_word(lnk.io_transfer_word), .function_command(lnk.function_command),
		.field_write_command(lnk.field_write_command), .word_taken(lnk.word_taken),
		.row_point(lnk.row_point), .irq(lnk.irq), .cycle_busy(lnk.cycle_busy));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// *****
	// result monitor
	// *****
	always @(posedge ref_clk) begin
		if (paper_step) begin
			n_step++;
			if (point_num < 4'h7 || point_num > 4'h9) bad_pt++;
		end
		if (print_strobe) begin
			n_prt++;
			if (point_num >= 4'h7 && point_num <= 4'h9) bad_pt++;
		end
		if (lnk.irq) n_irq++;
	end
	task automatic fail(string m);
		$display("[FAIL] %0t %s", $time, m);
		n_mismatch++;
	endtask
	task automatic cmp_cnt(int got, int exp, string m);
		check_count++;
		if (got != exp) fail(m);
	endtask
	task automatic cmp_chr(logic [5:0] got, logic [5:0] exp);
		check_count++;
		if (got !== exp) fail("character mismatch");
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// dig holds the expected index: 0 blank, 1..10 digits, 11..34 letters, 35 mark
	// pat blanks every third column so zero fill never chains
	task automatic mk(logic pat);
		int r;
		for (int i = 0; i < 16; i++) img[i] = '0;
		for (int c = 0; c < `LPOC_COLS; c++) begin
			dig[c] = $urandom_range(0, 35);
			if (pat) dig[c] = (c == 0 || c % 3 == 2) ? 0 : $urandom_range(1, 35);
			// lone row for digits and mark, zone row plus one for letters
			if (dig[c] >= 1 && dig[c] <= 10) img[dig[c] - 1][`LPOC_COLS-1-c] = 1'b1;
			if (dig[c] == 35) img[11][`LPOC_COLS-1-c] = 1'b1;
			if (dig[c] >= 11 && dig[c] <= 34) begin
				r = (dig[c] - 11) % 8;
				img[7 + (dig[c] - 11) / 8][`LPOC_COLS-1-c] = 1'b1;
				img[(r == 0) ? 11 : r - 1][`LPOC_COLS-1-c] = 1'b1;
			end
		end
	endtask
	task automatic chk_line(logic zf);
		logic [5:0] e;
		for (int c = 0; c < `LPOC_COLS; c++) begin
			e = 6'((dig[c] != 0) ? dig[c] : ((zf && c > 0 && dig[c-1] != 0) ? 1 : 0));
			cmp_chr(line_chars[c*6 +: 6], e);
		end
	endtask
	task automatic run(string nm, logic [35:0] f, logic zf, logic isw);
		int k;
		n_step = 0;
		n_prt = 0;
		n_irq = 0;
		bad_pt = 0;
		@(posedge ref_clk);
		func_bits <= f;
		auto_spaces <= 2'(as);
		format_spaces <= 4'(fs);
		zero_fill <= zf;
		irq_switch <= isw;
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		k = 0;
		while (!lnk.cycle_busy && k < 100) begin
			@(negedge ref_clk);
			k++;
		end
		if (!lnk.cycle_busy) begin
			fail("cycle never started");
			wrap_up();
		end
		while ((lnk.cycle_busy || host_busy) && k < 2000) begin
			@(negedge ref_clk);
			k++;
		end
		if (k >= 2000) begin
			fail("cycle never ended");
			wrap_up();
		end
		cmp_cnt(int'(row_missed !== '0), 0, "rows missed");
		$display("test %s done", nm);
	endtask
	// *****
	// main sequence
	// *****
	initial begin
		n_mismatch = 0;
		check_count = 0;
		go = 1'b0;
		func_bits = '0;
		auto_spaces = 2'h1;
		format_spaces = 4'h1;
		zero_fill = 1'b0;
		irq_switch = 1'b0;
		rst_n = 1'b0;
		fs = 1;
		void'($urandom(32'h4be5ad40));
		mk(1'b0);
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			mk(1'b0);
			as = $urandom_range(1, 3);
			run("print", 36'h4_0000_0400, 1'b0, 1'b0);
			cmp_cnt(n_prt, 1, "print count");
			cmp_cnt(n_step, as, "auto advance");
			cmp_cnt(bad_pt, 0, "advance or print point");
			cmp_cnt(n_irq, 0, "unexpected irq");
			chk_line(1'b0);
		end
		mk(1'b1);
		run("fill_hold", 36'h4_0000_0600, 1'b1, 1'b1);
		cmp_cnt(n_step, 0, "hold advanced");
		cmp_cnt(n_irq, 11, "switch irq count");
		chk_line(1'b1);
		run("irq_bit", 36'h4_0000_0c00, 1'b1, 1'b0);
		cmp_cnt(n_irq, 11, "irq bit count");
		run("jump", 36'h4_0000_2000, 1'b1, 1'b1);
		cmp_cnt(n_step, 9, "jump spaces");
		cmp_cnt(n_prt + n_irq, 0, "jump printed");
		chk_line(1'b1);
		fs = $urandom_range(1, 9);
		run("skip", 36'h4_0000_1000, 1'b0, 1'b0);
		cmp_cnt(n_step, fs, "skip spaces");
		cmp_cnt(n_prt, 0, "skip printed");
		wrap_up();
	end
endmodule
